/* File: hdl/brake_stop_regs.svh */
`ifndef BRAKE_STOP_REGS_SVH
`define BRAKE_STOP_REGS_SVH

`define ADR_CTRL       8'h00
`define ADR_ROT_LVL    8'h04
`define ADR_LIN_LVL    8'h08
`define ADR_WAIT       8'h0c
`define ADR_DELAY      8'h10
`define ADR_STATUS     8'h14
`define ADR_IRQ_STAT   8'h18
`define ADR_IRQ_MASK   8'h1c

`define CTRL_LINEAR    0
`define CTRL_RESTART   1
`define CTRL_SVOFF_LO  4
`define CTRL_SVOFF_HI  5
`define CTRL_G2_LO     8
`define CTRL_G2_HI     9

`define RST_ROT_LVL    14'h0064
`define RST_LIN_LVL    14'h000a
`define LVL_MAX        14'h2710
`define RST_WAIT       7'h32
`define WAIT_MIN       7'h0a
`define WAIT_MAX       7'h64
`define RST_DELAY      6'h00
`define DELAY_MAX      6'h32

`define IRQ_BRAKE      0
`define IRQ_HELD       1
`define IRQ_PWRLOSS    2
`define IRQ_ALARM      3
`define IRQ_W          4

`define WAIT_UNIT_NS   10000000
`define CLK_PERIOD_NS  10

`endif

/* File: hdl/brake_stop_pkg.sv */
package brake_stop_pkg;

  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,
    ST_RUN     = 5'h02,
    ST_ZSTOP   = 5'h04,
    ST_BRKWAIT = 5'h08,
    ST_DELAY   = 5'h10
  } seq_state_t;

  typedef enum logic [1:0] {
    STOP_DB_DB    = 2'h0,
    STOP_DB_COAST = 2'h1,
    STOP_COAST    = 2'h2
  } stop_method_t;

  typedef enum logic [1:0] {
    G2_ZERO_SPEED = 2'h0,
    G2_AS_G1      = 2'h1,
    G2_DECEL      = 2'h2
  } g2_method_t;

  typedef struct packed {
    logic         linear;
    logic [13:0]  rot_lvl;
    logic [13:0]  lin_lvl;
    logic [6:0]   wait_time;
    logic [5:0]   delay;
  } cfg_t;

  typedef struct packed {
    logic power_on;
    logic dyn_brake;
    logic zero_clamp;
    logic pos_hold;
    logic decel_estop;
  } drive_t;

endpackage : brake_stop_pkg

/* File: hdl/brake_tick_div.sv */
`timescale 1ns/10ps
module brake_tick_div #(
  parameter int TICK_CYCLES = 1000000
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  input  wire logic i_clear,
  output logic      o_tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_ff;

  // Restarted on each state entry so the first unit is a full one
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b)
      cnt_ff <= '0;
    else if (i_clear || cnt_ff == LAST)
      cnt_ff <= '0;
    else
      cnt_ff <= cnt_ff + CW'(1);

  assign o_tick = (cnt_ff == LAST) && !i_clear;
endmodule : brake_tick_div

/* File: hdl/speed_below_level.sv */
`timescale 1ns/10ps
module speed_below_level (
  input  wire logic signed [15:0] i_speed,
  input  wire logic        [13:0] i_level,
  output logic                    o_below
);
  logic [16:0] mag;

  // Direction does not matter for braking, so compare magnitude
  assign mag     = i_speed[15] ? 17'(-17'(i_speed)) : 17'(i_speed);
  assign o_below = mag < {3'h0, i_level};
endmodule : speed_below_level

/* File: hdl/brake_stop_sequencer.sv */
// Operation
// - Alarm while running starts a stop and drops brake release per timing.
// - Zero-speed alarm stop applies servo-off brake delay only after rest.
// - Rotary brake speed level 0..10000 rpm, default 100, immediate.
// - Linear brake speed level 0..10000 mm/s, default 10, immediate.
// - Brake wait after power off 10..100 x10 ms, default 50, immediate.
// - After power off, engage brake once speed falls below level.
// - After power off, engage brake once wait time elapses, whichever first.
// - Speed stays limited to motor maximum even with a higher level.
// - Four stop actions; three held states: dynamic brake, coast, clamp.
// - Zero clamp forces speed reference 0 then holds stop position.
// - Power loss while running always stops with dynamic brake.
// - Servo-off method 0 db/db, 1 db/coast, 2 coast/coast; after restart.
// - Alarms split into group one and two, each with own method.
// - Group one alarm stops with servo-off method, default dynamic brake.
// - Zero-speed stopping is the default for group two alarms.
// - Release output asserted frees brake; dropped on servo-off or alarm.
// - Overtravel keeps brake release asserted in every state except off.
`timescale 1ns/10ps
`include "brake_stop_regs.svh"
module brake_stop_sequencer #(
  parameter int TICK_CYCLES = `WAIT_UNIT_NS / `CLK_PERIOD_NS
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_wb_cyc,
  input  wire logic                   i_wb_stb,
  input  wire logic                   i_wb_we,
  input  wire logic [7:0]             i_wb_adr,
  input  wire logic [3:0]             i_wb_sel,
  input  wire logic [31:0]            i_wb_dat,
  output logic      [31:0]            o_wb_dat,
  output logic                        o_wb_ack,
  input  wire logic                   i_servo_off_command,
  input  wire logic                   i_alarm_group_one,
  input  wire logic                   i_alarm_group_two,
  input  wire logic                   i_power_lost,
  input  wire logic                   i_overtravel,
  input  wire logic signed [15:0]     i_motor_speed,
  input  wire logic        [15:0]     i_max_speed,
  output logic                        o_brake_release_out,
  output brake_stop_pkg::drive_t      o_drive,
  output logic             [15:0]     o_speed_limit,
  output logic                        o_irq
);
  generate
    if (TICK_CYCLES < 1)
      $error("TICK_CYCLES must be at least one");
  endgenerate

  brake_stop_pkg::seq_state_t   state_ff;
  brake_stop_pkg::seq_state_t   nxt_state;
  brake_stop_pkg::stop_method_t stop_ff;
  brake_stop_pkg::stop_method_t nxt_stop;
  brake_stop_pkg::stop_method_t pend_svoff_ff;
  brake_stop_pkg::stop_method_t act_svoff_ff;
  brake_stop_pkg::g2_method_t   pend_g2_ff;
  brake_stop_pkg::g2_method_t   act_g2_ff;
  brake_stop_pkg::cfg_t         cfg_ff;
  brake_stop_pkg::drive_t       nxt_drive;
  logic [`IRQ_W-1:0]            irq_stat_ff;
  logic [`IRQ_W-1:0]            irq_mask_ff;
  logic [`IRQ_W-1:0]            irq_evt;
  logic [6:0]                   tcnt_ff;
  logic [31:0]                  wb_dat_ff;
  logic [31:0]                  rd_mux;
  logic                         wb_ack_ff;
  logic                         brake_ff;
  logic                         nxt_brake;
  logic                         irq_ff;
  logic [15:0]                  speed_limit_ff;
  logic                         restart_ff;
  logic                         req;
  logic                         wr;
  logic                         rd;
  logic                         below;
  logic                         tick;
  logic                         state_chg;
  logic                         wait_done;
  logic                         delay_done;
  logic                         alarm_any;
  logic [13:0]                  lvl_sel;
  logic [31:0]                  wdat;

  // Merge write data into a register image lane by lane
  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[8*i +: 8] = dat[8*i +: 8];
    return res;
  endfunction : merge_lanes

  assign req = i_wb_cyc && i_wb_stb && !wb_ack_ff;
  // Writes land on the edge at which the master samples ack
  assign wr  = i_wb_cyc && i_wb_stb && wb_ack_ff && i_wb_we;
  assign rd  = req && !i_wb_we;

  always_comb
  begin
    rd_mux = 32'h0;
    unique case (i_wb_adr)
      `ADR_CTRL:
      begin
        rd_mux[`CTRL_LINEAR]                  = cfg_ff.linear;
        rd_mux[`CTRL_SVOFF_HI:`CTRL_SVOFF_LO] = pend_svoff_ff;
        rd_mux[`CTRL_G2_HI:`CTRL_G2_LO]       = pend_g2_ff;
      end
      `ADR_ROT_LVL:  rd_mux[13:0] = cfg_ff.rot_lvl;
      `ADR_LIN_LVL:  rd_mux[13:0] = cfg_ff.lin_lvl;
      `ADR_WAIT:     rd_mux[6:0]  = cfg_ff.wait_time;
      `ADR_DELAY:    rd_mux[5:0]  = cfg_ff.delay;
      `ADR_STATUS:   rd_mux[17:0] = {act_g2_ff, act_svoff_ff, stop_ff, below,
                                     brake_ff, o_drive, state_ff};
      `ADR_IRQ_STAT: rd_mux[`IRQ_W-1:0] = irq_stat_ff;
      `ADR_IRQ_MASK: rd_mux[`IRQ_W-1:0] = irq_mask_ff;
      default:       rd_mux = 32'h0;
    endcase
  end

  // Every access is answered, unmapped ones read zero and drop writes
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0;
    end
    else
    begin
      wb_ack_ff <= req;
      if (rd)
        wb_dat_ff <= rd_mux;
    end

  always_comb
  begin
    wdat = 32'h0;
    unique case (i_wb_adr)
      `ADR_CTRL:    wdat = merge_lanes({22'h0, pend_g2_ff, 2'h0, pend_svoff_ff,
                                        3'h0, cfg_ff.linear}, i_wb_dat, i_wb_sel);
      `ADR_ROT_LVL: wdat = merge_lanes({18'h0, cfg_ff.rot_lvl}, i_wb_dat, i_wb_sel);
      `ADR_LIN_LVL: wdat = merge_lanes({18'h0, cfg_ff.lin_lvl}, i_wb_dat, i_wb_sel);
      `ADR_WAIT:    wdat = merge_lanes({25'h0, cfg_ff.wait_time}, i_wb_dat, i_wb_sel);
      `ADR_DELAY:   wdat = merge_lanes({26'h0, cfg_ff.delay}, i_wb_dat, i_wb_sel);
      default:      wdat = merge_lanes({28'h0, irq_mask_ff}, i_wb_dat, i_wb_sel);
    endcase
  end

  // Out-of-range settings are dropped so the old value stays in force
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      cfg_ff.linear    <= 1'b0;
      cfg_ff.rot_lvl   <= `RST_ROT_LVL;
      cfg_ff.lin_lvl   <= `RST_LIN_LVL;
      cfg_ff.wait_time <= `RST_WAIT;
      cfg_ff.delay     <= `RST_DELAY;
      pend_svoff_ff    <= brake_stop_pkg::STOP_DB_DB;
      pend_g2_ff       <= brake_stop_pkg::G2_ZERO_SPEED;
      irq_mask_ff      <= '0;
      restart_ff       <= 1'b0;
    end
    else
    begin
      restart_ff <= wr && i_wb_adr == `ADR_CTRL && wdat[`CTRL_RESTART];
      if (wr)
        unique case (i_wb_adr)
          `ADR_CTRL:
          begin
            cfg_ff.linear <= wdat[`CTRL_LINEAR];
            if (wdat[`CTRL_SVOFF_HI:`CTRL_SVOFF_LO] <= 2'(brake_stop_pkg::STOP_COAST))
              pend_svoff_ff <= brake_stop_pkg::stop_method_t'(
                                 wdat[`CTRL_SVOFF_HI:`CTRL_SVOFF_LO]);
            if (wdat[`CTRL_G2_HI:`CTRL_G2_LO] <= 2'(brake_stop_pkg::G2_DECEL))
              pend_g2_ff <= brake_stop_pkg::g2_method_t'(wdat[`CTRL_G2_HI:`CTRL_G2_LO]);
          end
          `ADR_ROT_LVL:
            if (wdat[31:14] == 18'h0 && wdat[13:0] <= `LVL_MAX)
              cfg_ff.rot_lvl <= wdat[13:0];
          `ADR_LIN_LVL:
            if (wdat[31:14] == 18'h0 && wdat[13:0] <= `LVL_MAX)
              cfg_ff.lin_lvl <= wdat[13:0];
          `ADR_WAIT:
            if (wdat[31:7] == 25'h0 && wdat[6:0] >= `WAIT_MIN && wdat[6:0] <= `WAIT_MAX)
              cfg_ff.wait_time <= wdat[6:0];
          `ADR_DELAY:
            if (wdat[31:6] == 26'h0 && wdat[5:0] <= `DELAY_MAX)
              cfg_ff.delay <= wdat[5:0];
          `ADR_IRQ_MASK: irq_mask_ff <= wdat[`IRQ_W-1:0];
          default: ;
        endcase
    end

  // Stop methods only change on restart, so a plain write never switches a stop in progress
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      act_svoff_ff <= brake_stop_pkg::STOP_DB_DB;
      act_g2_ff    <= brake_stop_pkg::G2_ZERO_SPEED;
    end
    else if (restart_ff)
    begin
      act_svoff_ff <= pend_svoff_ff;
      act_g2_ff    <= pend_g2_ff;
    end

  assign lvl_sel = cfg_ff.linear ? cfg_ff.lin_lvl : cfg_ff.rot_lvl;

  speed_below_level u_below (
    .i_speed (i_motor_speed),
    .i_level (lvl_sel),
    .o_below (below)
  );

  assign state_chg = nxt_state != state_ff;

  brake_tick_div #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_clear   (state_chg),
    .o_tick    (tick)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b)
      tcnt_ff <= 7'h0;
    else if (state_chg)
      tcnt_ff <= 7'h0;
    else if (tick && tcnt_ff != `WAIT_MAX)
      tcnt_ff <= tcnt_ff + 7'h1;

  assign wait_done  = tcnt_ff >= cfg_ff.wait_time;
  assign delay_done = tcnt_ff >= {1'b0, cfg_ff.delay};
  assign alarm_any  = i_alarm_group_one || i_alarm_group_two;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_stop  = stop_ff;
    unique case (state_ff)
      brake_stop_pkg::ST_OFF:
        if (!i_servo_off_command && !alarm_any && !i_power_lost)
          nxt_state = brake_stop_pkg::ST_RUN;
      brake_stop_pkg::ST_RUN:
        if (i_power_lost)
        begin
          nxt_state = brake_stop_pkg::ST_BRKWAIT;
          nxt_stop  = brake_stop_pkg::STOP_DB_DB;
        end
        else if (i_alarm_group_two && act_g2_ff != brake_stop_pkg::G2_AS_G1)
          nxt_state = brake_stop_pkg::ST_ZSTOP;
        else if (alarm_any || i_servo_off_command)
        begin
          nxt_stop  = act_svoff_ff;
          // Servo-off of a stopped motor brakes first, then cuts power
          nxt_state = (below && !alarm_any) ? brake_stop_pkg::ST_DELAY
                                            : brake_stop_pkg::ST_BRKWAIT;
        end
      brake_stop_pkg::ST_ZSTOP:
        if (i_power_lost)
        begin
          nxt_state = brake_stop_pkg::ST_BRKWAIT;
          nxt_stop  = brake_stop_pkg::STOP_DB_DB;
        end
        else if (below)
        begin
          nxt_state = brake_stop_pkg::ST_DELAY;
          nxt_stop  = (act_svoff_ff == brake_stop_pkg::STOP_DB_DB)
                      ? brake_stop_pkg::STOP_DB_DB : brake_stop_pkg::STOP_COAST;
        end
      brake_stop_pkg::ST_BRKWAIT:
        if (below || wait_done)
          nxt_state = brake_stop_pkg::ST_OFF;
      brake_stop_pkg::ST_DELAY:
        if (i_power_lost)
        begin
          nxt_state = brake_stop_pkg::ST_OFF;
          nxt_stop  = brake_stop_pkg::STOP_DB_DB;
        end
        else if (delay_done)
          nxt_state = brake_stop_pkg::ST_OFF;
      default:
        nxt_state = brake_stop_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      state_ff <= brake_stop_pkg::ST_OFF;
      stop_ff  <= brake_stop_pkg::STOP_DB_DB;
    end
    else
    begin
      state_ff <= nxt_state;
      stop_ff  <= nxt_stop;
    end

  always_comb
  begin
    nxt_drive = '0;
    nxt_brake = 1'b0;
    unique case (nxt_state)
      brake_stop_pkg::ST_OFF:
        nxt_drive.dyn_brake = nxt_stop == brake_stop_pkg::STOP_DB_DB;
      brake_stop_pkg::ST_RUN:
      begin
        nxt_drive.power_on = 1'b1;
        nxt_brake          = 1'b1;
      end
      brake_stop_pkg::ST_ZSTOP:
      begin
        nxt_drive.power_on    = 1'b1;
        nxt_drive.zero_clamp  = act_g2_ff == brake_stop_pkg::G2_ZERO_SPEED;
        nxt_drive.decel_estop = act_g2_ff == brake_stop_pkg::G2_DECEL;
        nxt_brake             = 1'b1;
      end
      brake_stop_pkg::ST_BRKWAIT:
      begin
        // Power is already cut; brake waits for speed or time
        nxt_drive.dyn_brake = nxt_stop != brake_stop_pkg::STOP_COAST;
        nxt_brake           = 1'b1;
      end
      brake_stop_pkg::ST_DELAY:
      begin
        nxt_drive.power_on   = 1'b1;
        nxt_drive.zero_clamp = 1'b1;
        nxt_drive.pos_hold   = 1'b1;
      end
      default: ;
    endcase
    // Not at power-down rest: overtravel must not drop the brake
    if (i_overtravel && nxt_state != brake_stop_pkg::ST_OFF)
      nxt_brake = 1'b1;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      brake_ff       <= 1'b0;
      o_drive        <= '0;
      speed_limit_ff <= 16'h0;
    end
    else
    begin
      brake_ff       <= nxt_brake;
      o_drive        <= nxt_drive;
      speed_limit_ff <= i_max_speed;
    end

  assign irq_evt[`IRQ_BRAKE]   = brake_ff && !nxt_brake;
  assign irq_evt[`IRQ_HELD]    = state_chg && nxt_state == brake_stop_pkg::ST_OFF;
  assign irq_evt[`IRQ_PWRLOSS] = state_chg && i_power_lost;
  assign irq_evt[`IRQ_ALARM]   = state_chg && state_ff == brake_stop_pkg::ST_RUN &&
                                 alarm_any;

  // A new event in the clearing read cycle stays set
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      irq_stat_ff <= '0;
      irq_ff      <= 1'b0;
    end
    else
    begin
      if (rd && i_wb_adr == `ADR_IRQ_STAT)
        irq_stat_ff <= irq_evt;
      else
        irq_stat_ff <= irq_stat_ff | irq_evt;
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end

  assign o_wb_dat            = wb_dat_ff;
  assign o_wb_ack            = wb_ack_ff;
  assign o_brake_release_out = brake_ff;
  assign o_speed_limit       = speed_limit_ff;
  assign o_irq               = irq_ff;
endmodule : brake_stop_sequencer

/* File: testbench/brake_stop_monitor.sv */
`timescale 1ns/10ps
module brake_stop_monitor #(
  parameter int TICK_CYCLES = 8
) (
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst_b,
  input wire logic                   i_wb_cyc,
  input wire logic                   i_wb_stb,
  input wire logic                   o_wb_ack,
  input wire logic                   i_servo_off_command,
  input wire logic                   i_alarm_group_one,
  input wire logic                   i_power_lost,
  input wire logic                   i_overtravel,
  input wire logic [15:0]            i_max_speed,
  input wire logic                   o_brake_release_out,
  input wire brake_stop_pkg::drive_t o_drive,
  input wire logic [15:0]            o_speed_limit
);
  // Longest wait setting plus the exit edges
  localparam int WAIT_BOUND = 100 * TICK_CYCLES + 4;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  property p_ack_next;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("Bus request not acknowledged");

  property p_ack_pulse;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Acknowledge longer than one cycle");

  property p_limit;
    $past(i_rst_b) |-> o_speed_limit == $past(i_max_speed);
  endproperty
  a_limit: assert property (p_limit) else $error("Speed limit not following maximum");

  property p_power_loss;
    i_power_lost && o_drive.power_on && !o_drive.zero_clamp |=>
      !o_drive.power_on && o_drive.dyn_brake;
  endproperty
  a_power_loss: assert property (p_power_loss) else $error("Power loss without dynamic brake");

  property p_overtravel;
    i_overtravel && o_drive.power_on && !o_drive.pos_hold |=> o_brake_release_out;
  endproperty
  a_overtravel: assert property (p_overtravel) else $error("Brake engaged in overtravel");

  property p_wait_bound;
    $fell(o_drive.power_on) && o_brake_release_out && !i_overtravel |->
      ##[1:WAIT_BOUND] !o_brake_release_out;
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("Brake not engaged in wait time");

  property p_alarm_stop;
    i_alarm_group_one && o_drive.power_on && !o_drive.zero_clamp && !o_drive.pos_hold |=>
      !o_drive.power_on;
  endproperty
  a_alarm_stop: assert property (p_alarm_stop) else $error("Alarm did not start a stop");

  property p_servo_off;
    $rose(i_servo_off_command) && o_drive.power_on && !o_drive.zero_clamp |=>
      !o_drive.power_on || o_drive.zero_clamp;
  endproperty
  a_servo_off: assert property (p_servo_off) else $error("Servo off ignored");

  property p_hold_clamp;
    o_drive.pos_hold |-> o_drive.zero_clamp && o_drive.power_on;
  endproperty
  a_hold_clamp: assert property (p_hold_clamp) else $error("Position hold without clamp");
endmodule : brake_stop_monitor

bind brake_stop_sequencer brake_stop_monitor #(.TICK_CYCLES(TICK_CYCLES)) brake_stop_monitor_inst (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .o_wb_ack(o_wb_ack), .i_servo_off_command(i_servo_off_command),
  .i_alarm_group_one(i_alarm_group_one), .i_power_lost(i_power_lost),
  .i_overtravel(i_overtravel), .i_max_speed(i_max_speed),
  .o_brake_release_out(o_brake_release_out), .o_drive(o_drive), .o_speed_limit(o_speed_limit));

/* File: testbench/brake_motor_model.sv */
`timescale 1ns/10ps
module brake_motor_model (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_brake_release,
  input  wire brake_stop_pkg::drive_t i_drive,
  input  wire logic [15:0]            i_run_speed,
  input  wire logic [15:0]            i_step,
  output logic signed [15:0]          o_speed
);
  logic [15:0] spd_ff;

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      spd_ff <= 16'h0000;
    else if (i_drive.power_on && !i_drive.zero_clamp && !i_drive.decel_estop)
      spd_ff <= i_run_speed;
    else if (!i_brake_release)
      spd_ff <= 16'h0000; // Engaged brake holds the shaft
    else if (spd_ff > i_step)
      spd_ff <= spd_ff - i_step;
    else
      spd_ff <= 16'h0000;
  end

  assign o_speed = spd_ff;
endmodule : brake_motor_model

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
`include "brake_stop_regs.svh"
module tb_top;
  localparam int TICK = 8;
  logic                   i_sys_clk = 1'b0;
  logic                   i_rst_b = 1'b0;
  logic                   cyc, stb, we, svoff, g1, g2, pwr, ot, ack, brake, irq;
  logic [7:0]             adr;
  logic [31:0]            wdat, rdat, q;
  logic [15:0]            maxspd, run_spd, step, lim;
  logic signed [15:0]     speed;
  brake_stop_pkg::drive_t drv;
  int                     errors = 0;
  int                     n_checks = 0;
  int                     n;
  int                     lv;

  always #5 i_sys_clk = ~i_sys_clk;

  brake_stop_sequencer #(.TICK_CYCLES(TICK)) brake_stop_sequencer_inst (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_servo_off_command(svoff), .i_alarm_group_one(g1), .i_alarm_group_two(g2),
    .i_power_lost(pwr), .i_overtravel(ot), .i_motor_speed(speed), .i_max_speed(maxspd),
    .o_brake_release_out(brake), .o_drive(drv), .o_speed_limit(lim), .o_irq(irq));

  brake_motor_model brake_motor_model_inst (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_brake_release(brake), .i_drive(drv),
    .i_run_speed(run_spd), .i_step(step), .o_speed(speed));

  task automatic finish_test;
    $display("Checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do
    begin
      @(posedge i_sys_clk);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50)
    begin
      errors++;
      finish_test();
    end
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(q, exp);
  endtask : rd_chk

  // Sampled on the falling edge so design updates have landed
  task automatic wait_for(input int which, input logic lvl, input int cap);
    logic s;
    n = 0;
    do
    begin
      @(negedge i_sys_clk);
      n++;
      s = (which == 0) ? brake : (which == 1) ? drv.power_on : drv.zero_clamp;
    end
    while (s !== lvl && n < cap);
    if (s !== lvl)
    begin
      errors++;
      finish_test();
    end
  endtask : wait_for

  task automatic go_run;
    @(posedge i_sys_clk);
    svoff <= 1'b0;
    g1 <= 1'b0;
    g2 <= 1'b0;
    pwr <= 1'b0;
    wait_for(1, 1'b1, 50);
  endtask : go_run

  initial
  begin
    {cyc, stb, we, svoff, g1, g2, pwr, ot} = 8'h00;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    maxspd = 16'h1770;
    run_spd = 16'h0190;
    step = 16'h0003;
    repeat (2) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    rd_chk(`ADR_ROT_LVL, 32'h0000_0064);
    rd_chk(`ADR_LIN_LVL, 32'h0000_000a);
    rd_chk(`ADR_WAIT, 32'h0000_0032);
    rd_chk(`ADR_DELAY, 32'h0000_0000);
    rd_chk(`ADR_IRQ_MASK, 32'h0000_0000);
    rd_chk(8'h20, 32'h0000_0000);
    bus(1'b1, `ADR_ROT_LVL, 32'h0000_2711);
    rd_chk(`ADR_ROT_LVL, 32'h0000_0064);
    bus(1'b1, `ADR_ROT_LVL, 32'h0000_2710);
    rd_chk(`ADR_ROT_LVL, 32'h0000_2710);
    bus(1'b1, `ADR_ROT_LVL, 32'h0000_0064);
    bus(1'b1, `ADR_WAIT, 32'h0000_0009);
    rd_chk(`ADR_WAIT, 32'h0000_0032);
    bus(1'b1, `ADR_WAIT, 32'h0000_0065);
    rd_chk(`ADR_WAIT, 32'h0000_0032);
    bus(1'b1, `ADR_DELAY, 32'h0000_0033);
    rd_chk(`ADR_DELAY, 32'h0000_0000);
    @(posedge i_sys_clk);
    maxspd <= 16'h0bb8;
    repeat (3) @(negedge i_sys_clk);
    check(lim, 32'h0000_0bb8);
    // Speed level release, rotary then linear
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, `ADR_CTRL, 32'(i));
      @(posedge i_sys_clk);
      run_spd <= (i == 1) ? 16'h003c : 16'h0190;
      step <= (i == 1) ? 16'h0001 : 16'h0003;
      lv = (i == 1) ? 10 : 100;
      go_run();
      @(posedge i_sys_clk);
      g1 <= 1'b1;
      wait_for(1, 1'b0, 20);
      wait_for(0, 1'b0, 300);
      check(speed < lv && speed >= lv - 4 * int'(step), 1'b1);
    end
    bus(1'b1, `ADR_CTRL, 32'h0000_0000);
    // Wait time wins with a shaft that never slows
    bus(1'b1, `ADR_WAIT, 32'h0000_000a);
    @(posedge i_sys_clk);
    run_spd <= 16'h0190;
    step <= 16'h0000;
    go_run();
    @(posedge i_sys_clk);
    g1 <= 1'b1;
    wait_for(1, 1'b0, 20);
    wait_for(0, 1'b0, 200);
    check(n >= 10 * TICK - 1 && n <= 10 * TICK + 3, 1'b1);
    // Power loss, interrupt raised, masked and cleared
    @(posedge i_sys_clk);
    step <= 16'h0003;
    bus(1'b1, `ADR_IRQ_MASK, 32'h0000_0004);
    bus(1'b0, `ADR_IRQ_STAT, 32'h0000_0000);
    go_run();
    @(posedge i_sys_clk);
    pwr <= 1'b1;
    wait_for(1, 1'b0, 20);
    check(drv.dyn_brake, 1'b1);
    wait_for(0, 1'b0, 200);
    repeat (3) @(negedge i_sys_clk);
    check(irq, 1'b1);
    rd_chk(`ADR_IRQ_STAT, 32'h0000_0007);
    repeat (3) @(negedge i_sys_clk);
    check(irq, 1'b0);
    // Stop methods; group one alarm follows the servo-off field
    @(posedge i_sys_clk);
    run_spd <= 16'h0000;
    for (int m = 0; m < 3; m++)
    begin
      bus(1'b1, `ADR_CTRL, 32'(m * 16 + 2));
      go_run();
      @(posedge i_sys_clk);
      if (m == 1)
        g1 <= 1'b1;
      else
        svoff <= 1'b1;
      wait_for(1, 1'b0, 20);
      wait_for(0, 1'b0, 200);
      @(negedge i_sys_clk);
      check(drv.dyn_brake, m == 0);
      bus(1'b0, `ADR_STATUS, 32'h0000_0000);
      check(q[15:14], m[1:0]);
    end
    bus(1'b1, `ADR_CTRL, 32'h0000_0002);
    // Group two default clamps, delay runs only once at rest
    bus(1'b1, `ADR_DELAY, 32'h0000_0002);
    @(posedge i_sys_clk);
    run_spd <= 16'h00c8;
    step <= 16'h0004;
    go_run();
    @(posedge i_sys_clk);
    g2 <= 1'b1;
    wait_for(2, 1'b1, 5);
    check(drv.power_on, 1'b1);
    wait_for(0, 1'b0, 200);
    check(drv.power_on, 1'b1);
    check(drv.pos_hold, 1'b1);
    wait_for(1, 1'b0, 60);
    check(n >= 2 * TICK - 1 && n <= 2 * TICK + 3, 1'b1);
    // Group two by stop torque, then group two as group one
    for (int g = 2; g > 0; g--)
    begin
      bus(1'b1, `ADR_CTRL, 32'(g * 256 + 2));
      go_run();
      @(posedge i_sys_clk);
      g2 <= 1'b1;
      repeat (2) @(negedge i_sys_clk);
      check(drv.decel_estop, g == 2);
      check(drv.power_on, g == 2);
      wait_for(1, 1'b0, 100);
      wait_for(0, 1'b0, 300);
    end
    // Overtravel keeps the brake free through an alarm
    @(posedge i_sys_clk);
    ot <= 1'b1;
    go_run();
    @(posedge i_sys_clk);
    g1 <= 1'b1;
    repeat (20) @(negedge i_sys_clk);
    check(brake, 1'b1);
    @(posedge i_sys_clk);
    ot <= 1'b0;
    wait_for(0, 1'b0, 300);
    go_run();
    finish_test();
  end
endmodule : tb_top
